// ==== dv/ekc_host_model.sv ====
// Host controller model: task file writes and PIO data-out sectors.
// Assumes ekc_top on the far side, driven at the falling edge.
`timescale 1ns/1ps
`default_nettype none

module ekc_host_model (
  input wire logic clk_i,
  input wire logic pio_ready_i,
  output ekc_pkg::ekc_tf_wr_s tf_wr_o,
  output ekc_pkg::ekc_pio_word_s pio_o
);
  import ekc_pkg::*;

  initial begin
    tf_wr_o = '0;
    pio_o = '0;
  end

  // ====
  // Key word pattern
  function automatic logic [15:0] key_word(input logic [7:0] s, input int i);
    return {s, i[7:0] ^ 8'h5A};
  endfunction : key_word

  // ====
  // One register write, lines inverted once released
  task automatic tf_write(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_i);
    tf_wr_o = {1'b1, a, d};
    @(negedge clk_i);
    tf_wr_o = {1'b0, ~a, ~d};
  endtask : tf_write

  // ====
  // At most one sector, each word held until taken, giving up after 600 cycles
  task automatic send_sector(input logic [7:0] s, input logic [7:0] f,
      output int taken);
    int i;
    int n;
    logic r;
    i = 0;
    n = 0;
    @(negedge clk_i);
    while (i < 256 && n < 600) begin
      pio_o = {1'b1, (i < 16) ? key_word(s, i) : {f, i[7:0]}};
      r = pio_ready_i;
      @(negedge clk_i);
      if (r) begin
        i++;
      end
      n++;
    end
    pio_o = {1'b0, ~pio_o.data};
    taken = i;
  endtask : send_sector
endmodule : ekc_host_model
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the key command block.
// Assumes the host model drives the task file and PIO ports.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ekc_pkg::*;
  logic clk_i, reset_i, drive_id_i, nv_enc_en_i, sec_erase_i;
  logic pio_ready_o, usable_o, nv_store_o, nv_enc_clear_o, erase_o;
  logic [31:0] nv_hash_i, nv_hash_o;
  logic [3:0] key_raddr_i;
  logic [15:0] key_word_o;
  ekc_tf_wr_s tf_wr_i;
  ekc_pio_word_s pio_i;
  ekc_tf_rd_s tf_rd_o;
  int miscompares = 0;
  int total_checks = 0;
  int n_store = 0;
  int n_erase = 0;
  int n_clear = 0;

  ekc_top dut_u (
    .clk_i(clk_i), .reset_i(reset_i), .tf_wr_i(tf_wr_i), .pio_i(pio_i),
    .drive_id_i(drive_id_i), .nv_enc_en_i(nv_enc_en_i), .nv_hash_i(nv_hash_i),
    .sec_erase_i(sec_erase_i), .key_raddr_i(key_raddr_i), .pio_ready_o(pio_ready_o),
    .tf_rd_o(tf_rd_o), .usable_o(usable_o), .nv_store_o(nv_store_o),
    .nv_hash_o(nv_hash_o), .nv_enc_clear_o(nv_enc_clear_o), .erase_o(erase_o),
    .key_word_o(key_word_o)
  );

  ekc_host_model host_u (
    .clk_i(clk_i), .pio_ready_i(pio_ready_o), .tf_wr_o(tf_wr_i), .pio_o(pio_i)
  );

  // ====
  // Clock, inputs at time zero, pulse counters
  initial begin
    clk_i = 1'b0;
    reset_i = 1'b1;
    drive_id_i = 1'b1;
    nv_enc_en_i = 1'b0;
    nv_hash_i = 32'h0;
    sec_erase_i = 1'b0;
    key_raddr_i = 4'h0;
    forever #10 clk_i = ~clk_i;
  end

  always @(negedge clk_i) begin
    n_store += (nv_store_o === 1'b1);
    n_erase += (erase_o === 1'b1);
    n_clear += (nv_enc_clear_o === 1'b1);
  end

  // ====
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] khash(input logic [7:0] s);
    logic [31:0] h;
    h = 32'h0;
    for (int i = 0; i < 16; i++) begin
      h = {h[26:0], h[31:27]} ^ {i[7:0], 8'h00, host_u.key_word(s, i)};
    end
    return h;
  endfunction : khash

  task automatic power_up(input logic en, input logic [31:0] h);
    @(negedge clk_i);
    reset_i = 1'b1;
    nv_enc_en_i = en;
    nv_hash_i = h;
    repeat (5) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask : power_up

  task automatic run_key(input logic [7:0] s, input logic [7:0] f, input logic [7:0] code);
    int taken;
    host_u.tf_write(3'h6, 8'h10);
    host_u.tf_write(3'h7, 8'hFE);
    host_u.send_sector(s, f, taken);
    chk(taken, 256);
    repeat (2) @(negedge clk_i);
    chk(tf_rd_o.lba_mid, code);
    chk(tf_rd_o.status[0], code != 8'h00);
    chk(tf_rd_o.status[7:6], 2'h1);
    chk(tf_rd_o.error[2], code == 8'h02);
  endtask : run_key

  // ====
  // Scenarios
  task automatic t_first_key();
    int s0;
    chk(usable_o, 1'b1);
    host_u.tf_write(3'h6, 8'h10);
    host_u.tf_write(3'h7, 8'hEC);
    host_u.tf_write(3'h1, 8'hFE);
    host_u.tf_write(3'h6, 8'h00);
    host_u.tf_write(3'h7, 8'hFE);
    repeat (2) @(negedge clk_i);
    chk(pio_ready_o, 1'b0);
    s0 = n_store;
    run_key(8'h11, 8'h00, 8'h00);
    chk(n_store - s0, 1);
    chk(nv_hash_o, khash(8'h11));
    key_raddr_i = 4'h3;
    repeat (2) @(negedge clk_i);
    chk(key_word_o, host_u.key_word(8'h11, 3));
    run_key(8'h11, 8'h00, 8'h02);
    run_key(8'h12, 8'h00, 8'h01);
    chk(n_store - s0, 1);
  endtask : t_first_key

  task automatic t_locked();
    power_up(1'b1, khash(8'h11));
    chk(usable_o, 1'b0);
    run_key(8'h22, 8'h00, 8'h01);
    chk(usable_o, 1'b0);
    run_key(8'h11, 8'hC3, 8'h00);
    chk(usable_o, 1'b1);
  endtask : t_locked

  task automatic t_erase();
    int e0;
    int c0;
    power_up(1'b1, khash(8'h11));
    e0 = n_erase;
    run_key(8'h33, 8'h00, 8'h01);
    run_key(8'h44, 8'h00, 8'h01);
    chk(n_erase - e0, 0);
    run_key(8'h55, 8'h00, 8'h01);
    chk(n_erase - e0, 1);
    c0 = n_clear;
    sec_erase_i = 1'b1;
    @(negedge clk_i);
    sec_erase_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk(n_clear - c0, 1);
    chk(usable_o, 1'b1);
  endtask : t_erase

  // ====
  // Verdict, watchdog, main sequence
  task automatic close_out();
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    close_out();
  end

  initial begin
    power_up(1'b0, 32'h0);
    t_first_key();
    t_locked();
    t_erase();
    close_out();
  end
endmodule : tb
`default_nettype wire

// ==== src/ekc_consts.svh ====
// Constants for the encryption key command block.
// Assumes inclusion by bare name from the block's sources.
`ifndef EKC_CONSTS_SVH
`define EKC_CONSTS_SVH

// ==========================================================
// Command and task file
`define EKC_CMD_KEY 8'hFE
`define EKC_TF_DEVHEAD 3'h6
`define EKC_TF_CMD 3'h7
`define EKC_DEV_BIT 4

// ==========================================================
// Sector layout
`define EKC_KEY_WORDS 8'h10
`define EKC_SECTOR_LAST 8'hFF
`define EKC_WCNT_RST 8'h00

// ==========================================================
// Result codes
`define EKC_RES_OK 8'h00
`define EKC_RES_BADKEY 8'h01
`define EKC_RES_ABORT 8'h02

// ==========================================================
// Status and error bits
`define EKC_ST_BSY 7
`define EKC_ST_DRDY 6
`define EKC_ST_DRQ 3
`define EKC_ST_ERR 0
`define EKC_ERR_ABRT 2
`define EKC_ST_RST 8'h40
`define EKC_BYTE_ZERO 8'h00

// ==========================================================
// Hash and lockout
`define EKC_HASH_INIT 32'h0000_0000
`define EKC_FAIL_RST 2'h0
`define EKC_FAIL_ONE 2'h1
`define EKC_FAIL_LIMIT 2'h3

`endif

// ==== src/ekc_key_mem.sv ====
// Sixteen-word volatile key store with registered read port.
// Assumes one write and one read port in the same clock domain.
`timescale 1ns/1ps
`default_nettype none

module ekc_key_mem (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [3:0] waddr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [3:0] raddr_i,
  output logic [15:0] rdata_o
);

  logic [15:0] mem [0:15];

  // ==========================================================
  // Storage
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule : ekc_key_mem

`default_nettype wire

// ==== src/ekc_pkg.sv ====
// Types for the encryption key command block.
// Assumes ekc_consts.svh is present for the numeric values.
package ekc_pkg;

  // Task file register write from the host
  typedef struct packed {
    logic valid;
    logic [2:0] addr;
    logic [7:0] data;
  } ekc_tf_wr_s;

  // One PIO data-out word
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } ekc_pio_word_s;

  // Result task file contents
  typedef struct packed {
    logic [7:0] error;
    logic [7:0] lba_mid;
    logic [7:0] status;
  } ekc_tf_rd_s;

  typedef enum logic [1:0] {
    EKC_IDLE = 2'b00,
    EKC_XFER = 2'b01,
    EKC_CHECK = 2'b10
  } ekc_state_e;

endpackage : ekc_pkg

// ==== src/ekc_top.sv ====
// Encryption key load and unlock command handler, device side.
// Assumes a task file front end, a PIO word stream and nonvolatile
// storage of the key hash and the encryption-enabled flag outside.
//
// How it works
// - Command FEh with matching drive-select bit starts; other bytes ignored.
// - Words 0-15 form the key; words 16-255 are discarded.
// - Result code goes in LBA mid once the sector is in.
// - Code 0 accepted, 1 wrong key, 2 repeat of accepted key.
// - With a stored key the drive comes out of reset locked.
// - Correct key while locked unlocks the drive for data access.
// - With encryption enabled, data access stays blocked after each reset until key resent.
// - Received key is hashed and compared to the stored hash.
// - Third consecutive wrong key fires a secure erase.
// - Only a security erase disables encryption.
`timescale 1ns/1ps
`default_nettype none
`include "ekc_consts.svh"

module ekc_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire ekc_pkg::ekc_tf_wr_s tf_wr_i,
  input wire ekc_pkg::ekc_pio_word_s pio_i,
  input wire logic drive_id_i,
  input wire logic nv_enc_en_i,
  input wire logic [31:0] nv_hash_i,
  input wire logic sec_erase_i,
  input wire logic [3:0] key_raddr_i,
  output logic pio_ready_o,
  output ekc_pkg::ekc_tf_rd_s tf_rd_o,
  output logic usable_o,
  output logic nv_store_o,
  output logic [31:0] nv_hash_o,
  output logic nv_enc_clear_o,
  output logic erase_o,
  output logic [15:0] key_word_o
);
  import ekc_pkg::*;

  ekc_state_e state, next_state;
  logic [7:0] wcnt, next_wcnt;
  logic [31:0] hash, next_hash;
  logic [31:0] acc_hash, next_acc_hash;
  logic started, next_started;
  logic enc_en, next_enc_en;
  logic unlocked, next_unlocked;
  logic accepted, next_accepted;
  logic [1:0] fails, next_fails;
  ekc_tf_rd_s next_tf_rd;
  logic next_pio_ready, next_usable, next_nv_store, next_nv_clear, next_erase;
  logic [31:0] next_nv_hash;
  logic cmd_hit, word_take, key_we;
  logic [7:0] code;

  // ==========================================================
  // Key store
  assign word_take = pio_ready_o && pio_i.valid;
  assign key_we = word_take && (wcnt < `EKC_KEY_WORDS);

  ekc_key_mem u_key_mem (
    .clk_i(clk_i),
    .we_i(key_we),
    .waddr_i(wcnt[3:0]),
    .wdata_i(pio_i.data),
    .raddr_i(key_raddr_i),
    .rdata_o(key_word_o)
  );

  // ==========================================================
  // Command sequencer
  assign cmd_hit = tf_wr_i.valid && (tf_wr_i.addr == `EKC_TF_CMD)
      && (tf_wr_i.data == `EKC_CMD_KEY);

  always_comb begin
    next_state = state;
    next_wcnt = wcnt;
    next_hash = hash;
    next_acc_hash = acc_hash;
    next_started = 1'b1;
    next_enc_en = enc_en;
    next_unlocked = unlocked;
    next_accepted = accepted;
    next_fails = fails;
    next_tf_rd = tf_rd_o;
    next_pio_ready = 1'b0;
    next_nv_store = 1'b0;
    next_nv_hash = nv_hash_o;
    next_nv_clear = 1'b0;
    next_erase = 1'b0;
    code = `EKC_RES_OK;
    if (!started) begin
      next_enc_en = nv_enc_en_i;
      next_unlocked = 1'b0;
    end
    unique case (state)
      EKC_IDLE: begin
        if (cmd_hit && (tf_rd_o.status[`EKC_DEV_BIT] == drive_id_i)) begin
          next_state = EKC_XFER;
          next_wcnt = `EKC_WCNT_RST;
          next_hash = `EKC_HASH_INIT;
          next_pio_ready = 1'b1;
          next_tf_rd.status[`EKC_ST_BSY] = 1'b0;
          next_tf_rd.status[`EKC_ST_DRQ] = 1'b1;
        end
      end
      EKC_XFER: begin
        next_pio_ready = 1'b1;
        if (word_take) begin
          next_wcnt = wcnt + 8'h01;
          if (key_we) begin
            next_hash = {hash[26:0], hash[31:27]} ^ {wcnt, 8'h00, pio_i.data};
          end
          if (wcnt == `EKC_SECTOR_LAST) begin
            next_state = EKC_CHECK;
            next_pio_ready = 1'b0;
            next_tf_rd.status[`EKC_ST_DRQ] = 1'b0;
            next_tf_rd.status[`EKC_ST_BSY] = 1'b1;
          end
        end
      end
      EKC_CHECK: begin
        if (accepted && (hash == acc_hash)) begin
          code = `EKC_RES_ABORT;
        end else if (enc_en && !unlocked) begin
          if (hash == nv_hash_i) begin
            next_unlocked = 1'b1;
            next_accepted = 1'b1;
            next_acc_hash = hash;
            next_fails = `EKC_FAIL_RST;
          end else begin
            code = `EKC_RES_BADKEY;
            if (fails == `EKC_FAIL_LIMIT - `EKC_FAIL_ONE) begin
              next_erase = 1'b1;
              next_fails = `EKC_FAIL_RST;
            end else begin
              next_fails = fails + `EKC_FAIL_ONE;
            end
          end
        end else if (!enc_en && !accepted) begin
          next_accepted = 1'b1;
          next_acc_hash = hash;
          next_nv_store = 1'b1;
          next_nv_hash = hash;
        end else begin
          code = `EKC_RES_BADKEY;
        end
        next_tf_rd.lba_mid = code;
        next_tf_rd.error = `EKC_BYTE_ZERO;
        next_tf_rd.error[`EKC_ERR_ABRT] = (code == `EKC_RES_ABORT);
        next_tf_rd.status[`EKC_ST_ERR] = (code != `EKC_RES_OK);
        next_tf_rd.status[`EKC_ST_BSY] = 1'b0;
        next_tf_rd.status[`EKC_ST_DRDY] = 1'b1;
        next_state = EKC_IDLE;
      end
      default: begin
        next_state = EKC_IDLE;
      end
    endcase
    if (tf_wr_i.valid && (tf_wr_i.addr == `EKC_TF_DEVHEAD)) begin
      next_tf_rd.status[`EKC_DEV_BIT] = tf_wr_i.data[`EKC_DEV_BIT];
    end
    if (sec_erase_i) begin
      next_enc_en = 1'b0;
      next_unlocked = 1'b0;
      next_accepted = 1'b0;
      next_fails = `EKC_FAIL_RST;
      next_nv_clear = 1'b1;
    end
    next_usable = !next_enc_en || next_unlocked;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= EKC_IDLE;
      wcnt <= `EKC_WCNT_RST;
      hash <= `EKC_HASH_INIT;
      acc_hash <= `EKC_HASH_INIT;
      started <= 1'b0;
      enc_en <= 1'b1;
      unlocked <= 1'b0;
      accepted <= 1'b0;
      fails <= `EKC_FAIL_RST;
      tf_rd_o <= {`EKC_BYTE_ZERO, `EKC_BYTE_ZERO, `EKC_ST_RST};
      pio_ready_o <= 1'b0;
      usable_o <= 1'b0;
      nv_store_o <= 1'b0;
      nv_hash_o <= `EKC_HASH_INIT;
      nv_enc_clear_o <= 1'b0;
      erase_o <= 1'b0;
    end else begin
      state <= next_state;
      wcnt <= next_wcnt;
      hash <= next_hash;
      acc_hash <= next_acc_hash;
      started <= next_started;
      enc_en <= next_enc_en;
      unlocked <= next_unlocked;
      accepted <= next_accepted;
      fails <= next_fails;
      tf_rd_o <= next_tf_rd;
      pio_ready_o <= next_pio_ready;
      usable_o <= next_usable;
      nv_store_o <= next_nv_store;
      nv_hash_o <= next_nv_hash;
      nv_enc_clear_o <= next_nv_clear;
      erase_o <= next_erase;
    end
  end

  // ==========================================================
  // Checks
  property p_cmd_start;
    @(posedge clk_i) disable iff (reset_i)
    (state == EKC_IDLE && cmd_hit && tf_rd_o.status[`EKC_DEV_BIT] == drive_id_i
      && !(tf_wr_i.addr == `EKC_TF_DEVHEAD))
      |=> (state == EKC_XFER) && pio_ready_o && tf_rd_o.status[`EKC_ST_DRQ];
  endproperty
  a_cmd_start: assert property (p_cmd_start) else $error("key command not started");

  property p_key_only_low;
    @(posedge clk_i) disable iff (reset_i)
    key_we |-> (state == EKC_XFER) && (wcnt < `EKC_KEY_WORDS);
  endproperty
  a_key_only_low: assert property (p_key_only_low) else $error("key write outside words 0-15");

  property p_sector_end;
    @(posedge clk_i) disable iff (reset_i)
    (state == EKC_XFER && word_take && wcnt == `EKC_SECTOR_LAST)
      |=> (state == EKC_CHECK) && !pio_ready_o ##1 (state == EKC_IDLE);
  endproperty
  a_sector_end: assert property (p_sector_end) else $error("sector end not handled");

  property p_result_ready;
    @(posedge clk_i) disable iff (reset_i)
    (state == EKC_CHECK) |=> !tf_rd_o.status[`EKC_ST_BSY] && tf_rd_o.status[`EKC_ST_DRDY]
      && (tf_rd_o.lba_mid <= `EKC_RES_ABORT);
  endproperty
  a_result_ready: assert property (p_result_ready) else $error("result status wrong");

  property p_repeat_abort;
    @(posedge clk_i) disable iff (reset_i)
    (state == EKC_CHECK && accepted && hash == acc_hash)
      |=> (tf_rd_o.lba_mid == `EKC_RES_ABORT) && tf_rd_o.error[`EKC_ERR_ABRT];
  endproperty
  a_repeat_abort: assert property (p_repeat_abort) else $error("repeat key not aborted");

  property p_unlock;
    @(posedge clk_i) disable iff (reset_i)
    (state == EKC_CHECK && enc_en && !unlocked && !accepted && hash == nv_hash_i
      && !sec_erase_i) |=> unlocked && (tf_rd_o.lba_mid == `EKC_RES_OK) ##1 usable_o;
  endproperty
  a_unlock: assert property (p_unlock) else $error("matching key did not unlock");

  property p_locked;
    @(posedge clk_i) disable iff (reset_i)
    (started && enc_en && !unlocked) |-> !usable_o || $past(sec_erase_i);
  endproperty
  a_locked: assert property (p_locked) else $error("locked drive usable");

  property p_unlock_cause;
    @(posedge clk_i) disable iff (reset_i)
    (enc_en && $rose(usable_o)) |-> $past(state == EKC_CHECK && hash == nv_hash_i);
  endproperty
  a_unlock_cause: assert property (p_unlock_cause) else $error("unlock without match");

  property p_erase;
    @(posedge clk_i) disable iff (reset_i)
    (state == EKC_CHECK && enc_en && !unlocked && hash != nv_hash_i && !accepted
      && fails == `EKC_FAIL_LIMIT - `EKC_FAIL_ONE && !sec_erase_i)
      |=> erase_o && (fails == `EKC_FAIL_RST) ##1 !erase_o;
  endproperty
  a_erase: assert property (p_erase) else $error("third bad key no erase");

  property p_sec_erase;
    @(posedge clk_i) disable iff (reset_i)
    sec_erase_i |=> !enc_en && nv_enc_clear_o && usable_o;
  endproperty
  a_sec_erase: assert property (p_sec_erase) else $error("security erase kept encryption");

endmodule : ekc_top

`default_nettype wire
